// file: logic/fes_bus_if.sv
/*
 * Interface carrying one flash bus cycle request from the sequencer to the
 * pin driver and the answer back.
 * Assumes both ends share aclk.
 */
`timescale 1ns/1ps
`default_nettype none
interface fes_bus_if;
    logic req;
    logic wr;
    logic [20:0] addr;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    modport seq (output req, output wr, output addr, output wdata, input ack, input rdata);
    modport drv (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface : fes_bus_if
`default_nettype wire

// file: logic/fes_host_ctrl.sv
/*
 * Host controller for an asynchronous flash module: takes program, erase,
 * reset and status orders over AXI4-Lite, writes the command sequences and
 * watches the timing limit and erase timer flags on both byte lanes.
 * Assumes one 16-bit flash module of two byte-wide devices driven in step.
 */
// Summary of operation
// - After the flag, host writes the reset command to return to read; the controller sets fail and leaves this to a reset order.
// - Host may skip the timer check only if gaps stay under 50 us.
// - Host confirms acceptance by polling or toggle bit, then reads timer.
// - Host reads timer before and after each added sector erase; the controller skips the after-check once timer_seen is set.
// - Timer high at the after-check means command possibly not accepted.
// - Sector erase ends with 30, chip erase with 10.
`timescale 1ns/1ps
`default_nettype none
module fes_host_ctrl
    import fes_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Flash pins.
    output logic [20:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    output logic fl_reset_n,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_i
);
    typedef enum logic [3:0] {
        FES_IDLE, FES_HWRST, FES_WRITE, FES_PRECHK, FES_POLL1, FES_POLL2, FES_TIMER, FES_FINISH
    } fes_state_t;

    fes_bus_if bus ();
    fes_state_t state;
    logic [31:0] ctrl;
    logic [20:0] addr_reg;
    logic [15:0] data_reg;
    logic [15:0] rdata_reg;
    logic busy, fail, timer_seen, refused, done;
    logic [2:0] step;
    logic [2:0] last_step;
    logic [4:0] rst_cnt;
    logic [15:0] prev_read;
    logic start;
    fes_op_t op;

    // Doubles a command byte onto both device lanes.
    function automatic logic [15:0] both_lanes(input logic [7:0] b);
        return {b, b};
    endfunction : both_lanes

    // True when a status bit is set in either lane.
    function automatic logic lane_bit(input logic [15:0] d, input int pos);
        return d[pos] | d[pos + LANE_W];
    endfunction : lane_bit

    // AXI4-Lite write slave.
    logic aw_have, w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    assign s_axi_awready = !aw_have && !s_axi_bvalid;
    assign s_axi_wready = !w_have && !s_axi_bvalid;
    assign s_axi_bresp = 2'b00;
    assign s_axi_rresp = 2'b00;
    wire wr_fire = aw_have && w_have && !s_axi_bvalid;
    assign start = wr_fire && aw_addr == REG_CTRL && w_strb[0] && w_data[CTRL_GO_BIT] && !busy;
    assign op = fes_op_t'(w_data[CTRL_OP_LSB +: 3]);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
            addr_reg <= 21'h00_0000;
            data_reg <= 16'h0000;
        end else if (wr_fire && !busy) begin
            case (aw_addr)
                REG_CTRL: ctrl <= w_data;
                REG_ADDR: addr_reg <= w_data[20:0];
                REG_DATA: data_reg <= w_data[15:0];
                default: ;
            endcase
        end
    end

    // AXI4-Lite read slave; unmapped offsets read as zero.
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                REG_CTRL: s_axi_rdata <= ctrl;
                REG_ADDR: s_axi_rdata <= {11'h000, addr_reg};
                REG_DATA: s_axi_rdata <= {16'h0000, data_reg};
                REG_STATUS: s_axi_rdata <= {27'h000_0000, done, refused, timer_seen, fail, busy};
                REG_RDATA: s_axi_rdata <= {16'h0000, rdata_reg};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Command sequence table: step index to address and data.
    logic [20:0] seq_addr;
    logic [15:0] seq_data;
    fes_op_t cur_op;
    always_comb begin
        seq_addr = ADDR_555;
        seq_data = both_lanes(CMD_UNLOCK1);
        case (step)
            3'd0: seq_data = both_lanes(CMD_UNLOCK1);
            3'd1: begin
                seq_addr = ADDR_2AA;
                seq_data = both_lanes(CMD_UNLOCK2);
            end
            3'd2: seq_data = both_lanes(cur_op == FES_OP_PROGRAM ? CMD_PROGRAM : CMD_ERASE);
            3'd3: seq_data = both_lanes(CMD_UNLOCK1);
            3'd4: begin
                seq_addr = ADDR_2AA;
                seq_data = both_lanes(CMD_UNLOCK2);
            end
            default: begin
                seq_addr = (cur_op == FES_OP_CHIP) ? ADDR_555 : addr_reg;
                if (cur_op == FES_OP_PROGRAM) begin
                    seq_addr = addr_reg;
                    seq_data = data_reg;
                end else if (cur_op == FES_OP_CHIP) begin
                    seq_data = both_lanes(CMD_CHIP);
                end else if (cur_op == FES_OP_RESET) begin
                    seq_data = both_lanes(CMD_RESET);
                end else begin
                    seq_data = both_lanes(CMD_SECTOR);
                end
            end
        endcase
    end

    // Added sector commands skip straight to the final cycle of the sequence.
    wire [2:0] first_step = (op == FES_OP_ADD_SECTOR || op == FES_OP_RESET) ? 3'd5 : 3'd0;

    assign bus.wr = (state == FES_WRITE);
    assign bus.req = (state == FES_WRITE) || (state == FES_PRECHK) || (state == FES_POLL1)
        || (state == FES_POLL2) || (state == FES_TIMER);
    assign bus.addr = (state == FES_WRITE) ? seq_addr : addr_reg;
    assign bus.wdata = seq_data;
    assign last_step = 3'd5;

    wire limit_hit = lane_bit(bus.rdata, LIMIT_BIT);
    wire timer_hit = lane_bit(bus.rdata, TIMER_BIT);
    wire toggling = (bus.rdata[TOGGLE_BIT] != prev_read[TOGGLE_BIT])
        || (bus.rdata[TOGGLE_BIT + LANE_W] != prev_read[TOGGLE_BIT + LANE_W]);
    wire is_erase = (cur_op == FES_OP_SECTOR) || (cur_op == FES_OP_ADD_SECTOR);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= FES_IDLE;
            cur_op <= FES_OP_READ;
            step <= 3'd0;
            busy <= 1'b0;
            fail <= 1'b0;
            timer_seen <= 1'b0;
            refused <= 1'b0;
            done <= 1'b0;
            rst_cnt <= 5'h00;
            prev_read <= 16'h0000;
            rdata_reg <= 16'h0000;
            fl_reset_n <= 1'b1;
        end else begin
            case (state)
                FES_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        done <= 1'b0;
                        refused <= 1'b0;
                        cur_op <= op;
                        step <= first_step;
                        if (op == FES_OP_READ || op == FES_OP_STATUS) begin
                            state <= FES_POLL1;
                        end else if (op == FES_OP_ADD_SECTOR) begin
                            state <= FES_PRECHK;
                        end else if (op == FES_OP_RESET && w_data[CTRL_OP_LSB + 3]) begin
                            state <= FES_HWRST;
                            rst_cnt <= RESET_CYCLES;
                            fl_reset_n <= 1'b0;
                        end else begin
                            state <= FES_WRITE;
                        end
                    end
                end
                FES_HWRST: begin
                    if (rst_cnt > 5'h01) begin
                        rst_cnt <= rst_cnt - 5'h01;
                    end else begin
                        fl_reset_n <= 1'b1;
                        fail <= 1'b0;
                        timer_seen <= 1'b0;
                        state <= FES_FINISH;
                    end
                end
                FES_PRECHK: begin
                    if (bus.ack) begin
                        // Erase already started: further sector commands are pointless.
                        if (timer_hit) begin
                            refused <= 1'b1;
                            state <= FES_FINISH;
                        end else begin
                            state <= FES_WRITE;
                        end
                    end
                end
                FES_WRITE: begin
                    if (bus.ack) begin
                        if (step == last_step) begin
                            if (cur_op == FES_OP_RESET) begin
                                fail <= 1'b0;
                                timer_seen <= 1'b0;
                                state <= FES_FINISH;
                            end else begin
                                state <= FES_POLL1;
                            end
                        end else if (cur_op == FES_OP_PROGRAM && step == 3'd2) begin
                            step <= last_step;
                        end else begin
                            step <= step + 3'd1;
                        end
                    end
                end
                FES_POLL1: begin
                    if (bus.ack) begin
                        prev_read <= bus.rdata;
                        rdata_reg <= bus.rdata;
                        if (cur_op == FES_OP_READ || cur_op == FES_OP_STATUS) begin
                            state <= FES_FINISH;
                        end else begin
                            state <= FES_POLL2;
                        end
                    end
                end
                FES_POLL2: begin
                    if (bus.ack) begin
                        prev_read <= bus.rdata;
                        rdata_reg <= bus.rdata;
                        if (!toggling) begin
                            state <= FES_FINISH;
                        end else if (limit_hit) begin
                            fail <= 1'b1;
                            state <= FES_FINISH;
                        end else if (is_erase && !timer_seen) begin
                            state <= FES_TIMER;
                        end
                    end
                end
                FES_TIMER: begin
                    if (bus.ack) begin
                        // Keeps the toggle comparison between two consecutive reads.
                        prev_read <= bus.rdata;
                        rdata_reg <= bus.rdata;
                        if (timer_hit) begin
                            timer_seen <= 1'b1;
                            if (cur_op == FES_OP_ADD_SECTOR) begin
                                refused <= 1'b1;
                            end
                            state <= FES_POLL2;
                        end else begin
                            // Window still open: hand back so software may add sectors.
                            state <= FES_FINISH;
                        end
                    end
                end
                FES_FINISH: begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    state <= FES_IDLE;
                end
                default: state <= FES_IDLE;
            endcase
        end
    end

    fes_pin_drv u_drv (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus(bus.drv),
        .fl_addr(fl_addr),
        .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe),
        .fl_dq_i(fl_dq_i)
    );

    a_fail_on_limit: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == FES_POLL2 && bus.ack && toggling && limit_hit) |=> fail)
        else $error("limit flag not reported");
    a_fail_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        (fail && !(state == FES_WRITE && cur_op == FES_OP_RESET) && state != FES_HWRST) |=> fail)
        else $error("fail cleared without reset");
    a_sector_code: assert property (@(posedge aclk) disable iff (!aresetn)
        (bus.req && bus.wr && step == 3'd5 && cur_op == FES_OP_SECTOR) |-> bus.wdata == 16'h3030)
        else $error("wrong sector erase code");
    a_chip_code: assert property (@(posedge aclk) disable iff (!aresetn)
        (bus.req && bus.wr && step == 3'd5 && cur_op == FES_OP_CHIP) |-> bus.wdata == 16'h1010)
        else $error("wrong chip erase code");
    a_chip_no_timer: assert property (@(posedge aclk) disable iff (!aresetn)
        (cur_op == FES_OP_CHIP) |-> state != FES_TIMER)
        else $error("timer checked on chip erase");
    a_add_prechk: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == FES_IDLE && start && op == FES_OP_ADD_SECTOR) |=> state == FES_PRECHK)
        else $error("no check before added sector");
    a_refuse_late: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == FES_TIMER && bus.ack && timer_hit && cur_op == FES_OP_ADD_SECTOR) |=> refused)
        else $error("late acceptance not flagged");
    a_reset_clears: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == FES_WRITE && bus.ack && step == 3'd5 && cur_op == FES_OP_RESET) |=> !fail ##1 !busy)
        else $error("reset command did not clear fail");
endmodule : fes_host_ctrl
`default_nettype wire

// file: logic/fes_pin_drv.sv
/*
 * Flash pin driver: performs one timed write or read cycle on the flash pins.
 * Assumes the flash data pins are two-way and resolved outside.
 */
`timescale 1ns/1ps
`default_nettype none
module fes_pin_drv
    import fes_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Request side.
    fes_bus_if.drv bus,
    // Flash pins.
    output logic [20:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_i
);
    typedef enum logic [1:0] {FES_D_IDLE, FES_D_ACT, FES_D_DONE} fes_drv_t;
    fes_drv_t state;
    logic [3:0] cnt;
    logic wr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= FES_D_IDLE;
            cnt <= 4'h0;
            wr <= 1'b0;
            fl_addr <= 21'h00_0000;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_dq_o <= 16'h0000;
            fl_dq_oe <= 1'b0;
            bus.rdata <= 16'h0000;
        end else begin
            case (state)
                FES_D_IDLE: begin
                    if (bus.req) begin
                        state <= FES_D_ACT;
                        wr <= bus.wr;
                        fl_addr <= bus.addr;
                        fl_dq_o <= bus.wdata;
                        fl_dq_oe <= bus.wr;
                        fl_ce_n <= 1'b0;
                        fl_we_n <= !bus.wr;
                        fl_oe_n <= bus.wr;
                        cnt <= bus.wr ? WE_CYCLES : READ_CYCLES;
                    end
                end
                FES_D_ACT: begin
                    if (cnt > 4'h1) begin
                        cnt <= cnt - 4'h1;
                    end else begin
                        if (!wr) begin
                            bus.rdata <= fl_dq_i;
                        end
                        fl_we_n <= 1'b1;
                        fl_oe_n <= 1'b1;
                        fl_ce_n <= 1'b1;
                        state <= FES_D_DONE;
                    end
                end
                FES_D_DONE: begin
                    fl_dq_oe <= 1'b0;
                    state <= FES_D_IDLE;
                end
                default: state <= FES_D_IDLE;
            endcase
        end
    end

    assign bus.ack = (state == FES_D_DONE);
endmodule : fes_pin_drv
`default_nettype wire

// file: logic/fes_pkg.sv
/*
 * Package for the flash erase/status host controller: register map of the
 * controller's own AXI4-Lite slave, flash command codes, status bit positions
 * and bus cycle timing counts.
 * Assumes a 40 MHz aclk and a 16-bit flash module with two byte lanes.
 */
package fes_pkg;
    // Own register offsets (byte addresses).
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA = 8'h10;
    // Control register fields.
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Status register fields.
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_FAIL_BIT = 1;
    localparam int ST_TIMER_BIT = 2;
    localparam int ST_REFUSED_BIT = 3;
    localparam int ST_DONE_BIT = 4;
    // Flash status bit positions per byte lane.
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int LIMIT_BIT = 5;
    localparam int TIMER_BIT = 3;
    localparam int LANE_W = 8;
    // Flash command bytes, doubled onto both lanes.
    localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_ERASE = 8'h80;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_SECTOR = 8'h30;
    localparam logic [7:0] CMD_CHIP = 8'h10;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [20:0] ADDR_555 = 21'h00_0555;
    localparam logic [20:0] ADDR_2AA = 21'h00_02aa;
    // Timing.
    localparam int CLK_PERIOD_NS = 25;
    localparam int WE_PULSE_NS = 50;
    localparam int READ_ACC_NS = 150;
    localparam int RESET_PULSE_NS = 500;
    localparam int SECTOR_GAP_US = 50;
    localparam logic [3:0] WE_CYCLES = 4'((WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] READ_CYCLES = 4'((READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] RESET_CYCLES = 5'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] SECTOR_GAP_CYCLES = 12'((SECTOR_GAP_US * 1000) / CLK_PERIOD_NS);
    // Operations requested through the control register.
    typedef enum logic [2:0] {
        FES_OP_READ, FES_OP_PROGRAM, FES_OP_SECTOR, FES_OP_ADD_SECTOR,
        FES_OP_CHIP, FES_OP_RESET, FES_OP_STATUS
    } fes_op_t;
endpackage : fes_pkg

// file: verif/fes_flash_model.sv
/* Flash device model: decodes command bytes, reports toggle, limit and erase timer flags.
   Assumes registered host pins on aclk; status is doubled on both byte lanes. */
`timescale 1ns/1ps
`default_nettype none
module fes_flash_model #(parameter int TOUT = 3000) (
    // Clock and pins.
    input wire logic aclk,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic [15:0] dq_o,
    output logic [15:0] dq_i
);
    logic arm = 0, ers = 0, limit = 0, tog = 0, fails = 0, pw = 1, po = 1, pc = 1;
    int tmr = 0, left = 0;
    logic [15:0] last = 0;
    logic [7:0] st;
    assign st = {1'b0, tog, limit, 1'b0, ers && tmr == 0, 3'b000};
    // Released bus shows the inverse of the last value driven.
    assign dq_i = (!ce_n && !oe_n) ? (left > 0 ? {st, st} : 16'h0000) : ~last;
    always @(posedge aclk) begin
        pw <= we_n;
        po <= oe_n;
        pc <= ce_n;
        if (!ce_n && !oe_n) last <= dq_i;
        if (tmr > 0) tmr <= tmr - 1;
        if (!pw && we_n && !pc) begin
            if (arm) begin
                arm <= 0;
                left <= 4;
                fails <= (dq_o != 16'h0000);
            end else if (dq_o[7:0] == 8'hf0) begin
                ers <= 0;
                limit <= 0;
                fails <= 0;
                left <= 0;
            end else if (dq_o[7:0] == 8'ha0) arm <= 1;
            else if (dq_o[7:0] == 8'h30 && !(ers && tmr == 0)) begin
                ers <= 1;
                tmr <= TOUT;
                left <= 8;
            end else if (dq_o[7:0] == 8'h10 && !ers) begin
                ers <= 1;
                tmr <= 0;
                left <= 8;
            end
        end
        if (!po && oe_n && !pc && left > 0) begin
            tog <= ~tog;
            if (fails && left == 1) limit <= 1;
            else if (!(ers && tmr > 0)) begin
                left <= left - 1;
                if (left == 1) ers <= 0;
            end
        end
        // A low reset pin abandons any embedded operation.
        if (!reset_n) begin
            ers <= 0;
            limit <= 0;
            fails <= 0;
            left <= 0;
            arm <= 0;
        end
    end
endmodule : fes_flash_model
`default_nettype wire

// file: verif/flash_erase_status_timer_tb_top.sv
/* Testbench for the flash host controller: AXI4-Lite orders, flash model on the pins.
   Assumes the controller's own register map from the package. */
`timescale 1ns/1ps
`default_nettype none
module flash_erase_status_timer_tb_top;
    import fes_pkg::*;
    localparam int TOUT = 3000;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, st, ra;
    logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n, dq_oe, fl_rst_n;
    logic [1:0] bresp, rresp;
    logic [15:0] dq_o, dq_i;
    int bad_count = 0, n_tests = 0;
    always #12.5 aclk = ~aclk;
    fes_host_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fl_addr(), .fl_ce_n(ce_n),
        .fl_oe_n(oe_n), .fl_we_n(we_n), .fl_reset_n(fl_rst_n), .fl_dq_o(dq_o), .fl_dq_oe(dq_oe), .fl_dq_i(dq_i));
    fes_flash_model #(.TOUT(TOUT)) flash_u (.aclk(aclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .reset_n(fl_rst_n), .dq_o(dq_o), .dq_i(dq_i));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit pa, pd;
        pa = 1;
        pd = 1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge aclk);
            if (pa && awready) begin pa = 0; awvalid <= 0; end
            if (pd && wready) begin pd = 0; wvalid <= 0; end
        end while (pa || pd || !bvalid);
        bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bit pa;
        pa = 1;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            if (pa && arready) begin pa = 0; arvalid <= 0; end
        end while (pa || !rvalid);
        d = rdata;
        rready <= 0;
    endtask : rd
    task automatic op(input logic [3:0] code, input logic [31:0] d);
        wr(REG_ADDR, ra);
        wr(REG_DATA, d);
        wr(REG_CTRL, {27'h0, code, 1'b1});
        do rd(REG_STATUS, st); while (st[ST_BUSY_BIT] !== 1'b0);
    endtask : op
    task automatic finish_test();
        $display("tests %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    initial begin
        repeat (40000) @(posedge aclk);
        bad_count++;
        finish_test();
    end
    initial begin
        ra = $urandom(32'h401985ee);
        ra = {11'h0, 21'($urandom)};
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        rd(REG_STATUS, st);
        chk(st, 32'h0, "status after reset");
        rd(8'h20, st);
        chk(st, 32'h0, "unmapped read");
        op(3'd1, 32'h0);
        chk(st & 32'h2, 32'h0, "program zeros");
        op(3'd1, {16'h0, 16'($urandom_range(65535, 1))});
        chk(st & 32'h2, 32'h2, "program one over zero");
        op(3'd6, 32'h0);
        chk(st & 32'h2, 32'h2, "limit held");
        op(4'hd, 32'h0);
        chk(st & 32'h2, 32'h0, "pin reset");
        op(3'd6, 32'h0);
        rd(REG_RDATA, st);
        chk(st, 32'h0, "flash idle after pin reset");
        op(3'd5, 32'h0);
        chk(st & 32'h2, 32'h0, "reset command");
        op(3'd2, 32'h0);
        chk(st & 32'he, 32'h0, "sector window open");
        repeat (100) @(posedge aclk);
        op(3'd3, 32'h0);
        chk(st & 32'he, 32'h0, "add sector accepted");
        repeat (TOUT + 200) @(posedge aclk);
        op(3'd3, 32'h0);
        chk(st & 32'he, 32'h8, "add sector late");
        op(3'd2, 32'h0);
        chk(st & 32'he, 32'h4, "erase timer seen");
        op(3'd5, 32'h0);
        op(3'd4, 32'h0);
        chk(st & 32'h7, 32'h0, "chip erase");
        finish_test();
    end
endmodule : flash_erase_status_timer_tb_top
`default_nettype wire
